// [shared/mcd_regs.vh]
// Operation
// - Commands 23,0-23,3 microjump on sign true/false, zero true/false.
// - Commands 24,0-24,3 next macro on signed-greater true/false, carry true/false.
// - Commands 25,0-25,3 next macro on sign true/false, zero true/false.
// - Commands 26,0-26,3 macro jump P-relative, base, indirect, index.
// - 27,0 jumps index plus base; 27,1 jumps indirect index.
// - 27,3 fetches next macro P-relative; 27,2 continues logical bank.
// - Commands 30,0-31,1 read memory in six address modes, in order.
// - 31,2 reads first half of 32-bit indirect address; 31,3 reads next address.
// - Commands 32,0-33,1 write memory in the same six address modes.
// - 33,2 writes last address; 33,3 writes next address.
// - 34,0-34,2 read bus address via current, alternate or last page table.
// - 34,3 reads physically, upper address bits from segment register.
// - 35,0-35,2 write bus address via current, alternate or last page table.
// - 35,3 writes physically, upper address bits from segment register.
// - 36,0 sets control-store address, 36,1 accesses it, only if fitted.
// - 36,2 loads logical bank, 36,3 loads alternate logical bank.
// - Bits 37-41 select one internal data bus source per code.
// - Sources 0-6: ALU, bit mask, general, read data, argument, file, status.
// - Bit mask source drives exactly one set bit.
// - Source 10 drives the four-bit B operand on bits 0-3.
// - Source 16 drives the I/O control register.
// - Source 27 drives the panel interrupt vector.
// - Source 34 combines locality bits 10-15 and control address bits 0-9.
// - Source 12 drives parity error address; source 13 parity status.
// - Each source enabled by memory-unit, ALU fast-bus or transfer enable.
`ifndef MCD_REGS_VH
`define MCD_REGS_VH
`define MCD_CMD_COND_MICROJUMP 5'h13
`define MCD_CMD_CNXA 5'h14
`define MCD_CMD_CNXB 5'h15
`define MCD_CMD_JMPA 5'h16
`define MCD_CMD_JMPB 5'h17
`define MCD_CMD_RDA 5'h18
`define MCD_CMD_RDB 5'h19
`define MCD_CMD_WRA 5'h1a
`define MCD_CMD_WRB 5'h1b
`define MCD_CMD_RPT 5'h1c
`define MCD_CMD_WPT 5'h1d
`define MCD_CMD_CSB 5'h1e
`define MCD_CMD_MBX 5'h1f
`define MCD_SRC_ALU 5'h00
`define MCD_SRC_BMG 5'h01
`define MCD_SRC_GPR 5'h02
`define MCD_SRC_DRD 5'h03
`define MCD_SRC_ARG 5'h04
`define MCD_SRC_REG 5'h05
`define MCD_SRC_STS 5'h06
`define MCD_SRC_B_OPERAND_ARGUMENT 5'h08
`define MCD_SRC_SWAP 5'h09
`define MCD_SRC_PEA 5'h0a
`define MCD_SRC_PES 5'h0b
`define MCD_SRC_A_OPERAND_ARGUMENT 5'h0c
`define MCD_SRC_IOR 5'h0e
`define MCD_SRC_DSIF 5'h0f
`define MCD_SRC_GSEX 5'h12
`define MCD_SRC_PGS 5'h13
`define MCD_SRC_PCR 5'h15
`define MCD_SRC_ALD 5'h16
`define MCD_SRC_PANEL 5'h17
`define MCD_SRC_INTERRUPT_VECTOR_SOURCE 5'h19
`define MCD_SRC_PTC 5'h1b
`define MCD_SRC_LACA 5'h1c
`define MCD_SRC_INSTALLATION_NUMBER_READ 5'h1d
`define MCD_SRC_FAST_INTERNAL_BUS 5'h1f
`define MCD_EN_MEM 2'h1
`define MCD_EN_ALU 2'h2
`define MCD_EN_XFER 2'h3
`define MCD_MODE_P 3'h0
`define MCD_MODE_B 3'h1
`define MCD_MODE_I 3'h2
`define MCD_MODE_X 3'h3
`define MCD_MODE_XB 3'h4
`define MCD_MODE_XI 3'h5
`define MCD_MODE_NEXT 3'h6
`define MCD_MODE_HOLD 3'h7
`define MCD_PT_CUR 2'h0
`define MCD_PT_ALT 2'h1
`define MCD_PT_LAST 2'h2
`define MCD_PT_PHYS 2'h3
`endif

// [rtl/mcd_bitmask.v]
`timescale 1ns/1ps
`default_nettype none
module mcd_bitmask
(
   // Bit position.
   input wire [3:0] pos,
   // One-hot word.
   output wire [15:0] mask
);

   // Shift a single one into place so exactly one bit is set.
   assign mask = 16'h0001 << pos;

endmodule // mcd_bitmask
`default_nettype wire

// [rtl/mcd_decode.v]
`timescale 1ns/1ps
`default_nettype none
`include "mcd_regs.vh"
module mcd_decode
(
   // Clock and reset.
   input wire MCLK,
   input wire RESET_N,
   // Microinstruction fields.
   input wire [4:0] CMD_CODE,
   input wire [1:0] CMD_SUB,
   input wire [4:0] BUS_SOURCE_SELECT,
   // Option strap.
   input wire WRITABLE_CONTROL_STORE,
   // Condition flags.
   input wire SIGN_FLAG,
   input wire ZERO_FLAG,
   input wire SIGNED_GREATER_FLAG,
   input wire CARRY_FLAG,
   // Source data.
   input wire [15:0] ALU_RESULT,
   input wire [3:0] MASK_POS,
   input wire [15:0] GENERAL_REGISTER,
   input wire [15:0] DATA_READ_REGISTER,
   input wire [15:0] MICRO_ARGUMENT,
   input wire [15:0] REGFILE_DATA,
   input wire [15:0] STATUS_REGISTER,
   input wire [3:0] B_OPERAND,
   input wire [3:0] A_OPERAND,
   input wire [15:0] SWAP_REGISTER,
   input wire [15:0] PARITY_ERROR_ADDR,
   input wire [15:0] PARITY_ERROR_STATUS,
   input wire [15:0] IO_CONTROL_REGISTER,
   input wire [15:0] DISABLE_IF_DATA,
   input wire [15:0] PAGING_STATUS,
   input wire [15:0] PAGING_CONTROL,
   input wire [15:0] AL_DESCRIPTOR,
   input wire [15:0] PANEL_VECTOR,
   input wire [15:0] INTERRUPT_VECTOR_SOURCE,
   input wire [15:0] PAGE_TABLE_CONTENT,
   input wire [5:0] LOCALITY_BITS,
   input wire [9:0] CONTROL_ADDR,
   input wire [15:0] INSTALLATION_NUMBER,
   input wire [15:0] FAST_INTERNAL_BUS,
   // Microsequencer controls.
   output reg COND_MICROJUMP,
   output reg COND_NEXT_MACRO,
   output reg MACRO_JUMP,
   output reg FETCH_NEXT,
   output reg LOGICAL_BANK_CONTINUE,
   output reg [2:0] JUMP_MODE,
   // Memory controls.
   output reg ADDR_MODE_READ,
   output reg ADDR_MODE_WRITE,
   output reg INDIRECT_FIRST_HALF_READ,
   output reg [2:0] ADDR_MODE,
   output reg BUS_ADDR_READ,
   output reg BUS_ADDR_WRITE,
   output reg [1:0] PAGE_TABLE_SEL,
   output reg SET_CONTROL_STORE_ADDR,
   output reg CONTROL_STORE_ACCESS,
   output reg LOAD_LOGICAL_BANK,
   output reg LOAD_ALT_LOGICAL_BANK,
   // Data bus.
   output reg [15:0] INTERNAL_DATA_BUS,
   output reg MEMORY_UNIT_OUT_ENABLE,
   output reg ALU_FAST_BUS_ENABLE,
   output reg BUS_TO_FAST_TRANSFER
);

   // One-hot word from the bit mask generator.
   wire [15:0] bm_word;

   // Next values of the microsequencer controls.
   reg cond_microjump_next;
   reg cond_next_macro_next;
   reg mjmp_next;
   reg fetch_next;
   reg lbc_next;
   reg [2:0] jmode_next;

   // Next values of the memory controls.
   reg ard_next;
   reg awr_next;
   reg ird2_next;
   reg [2:0] amode_next;
   reg brd_next;
   reg bwr_next;
   reg [1:0] pt_next;
   reg csa_next;
   reg csx_next;
   reg llb_next;
   reg lalb_next;

   // Next bus word, its enable path and the address mode of a read or write group.
   reg [15:0] bus_next;
   reg [1:0] en_next;
   reg [2:0] mode6;

   mcd_bitmask u_mask
   (
      .pos(MASK_POS),
      .mask(bm_word)
   );

   // Command decode; unlisted and mailbox codes leave every strobe low.
   always @*
   begin
      cond_microjump_next = 1'b0;
      cond_next_macro_next = 1'b0;
      mjmp_next = 1'b0;
      fetch_next = 1'b0;
      lbc_next = 1'b0;
      jmode_next = `MCD_MODE_P;
      ard_next = 1'b0;
      awr_next = 1'b0;
      ird2_next = 1'b0;
      amode_next = `MCD_MODE_P;
      brd_next = 1'b0;
      bwr_next = 1'b0;
      pt_next = `MCD_PT_CUR;
      csa_next = 1'b0;
      csx_next = 1'b0;
      llb_next = 1'b0;
      lalb_next = 1'b0;
      // The second word of each group starts at mode XB, then XI.
      mode6 = {1'b0, CMD_SUB};
      if (CMD_CODE[0])
      begin
         mode6 = {2'h2, CMD_SUB[0]};
      end
      case (CMD_CODE)
         `MCD_CMD_COND_MICROJUMP:
         begin
            case (CMD_SUB)
               2'h0: cond_microjump_next = SIGN_FLAG;
               2'h1: cond_microjump_next = ~SIGN_FLAG;
               2'h2: cond_microjump_next = ZERO_FLAG;
               default: cond_microjump_next = ~ZERO_FLAG;
            endcase
         end
         `MCD_CMD_CNXA:
         begin
            case (CMD_SUB)
               2'h0: cond_next_macro_next = SIGNED_GREATER_FLAG;
               2'h1: cond_next_macro_next = ~SIGNED_GREATER_FLAG;
               2'h2: cond_next_macro_next = CARRY_FLAG;
               default: cond_next_macro_next = ~CARRY_FLAG;
            endcase
         end
         `MCD_CMD_CNXB:
         begin
            case (CMD_SUB)
               2'h0: cond_next_macro_next = SIGN_FLAG;
               2'h1: cond_next_macro_next = ~SIGN_FLAG;
               2'h2: cond_next_macro_next = ZERO_FLAG;
               default: cond_next_macro_next = ~ZERO_FLAG;
            endcase
         end
         `MCD_CMD_JMPA:
         begin
            mjmp_next = 1'b1;
            jmode_next = {1'b0, CMD_SUB};
         end
         `MCD_CMD_JMPB:
         begin
            case (CMD_SUB)
               2'h0:
               begin
                  mjmp_next = 1'b1;
                  jmode_next = `MCD_MODE_XB;
               end
               2'h1:
               begin
                  mjmp_next = 1'b1;
                  jmode_next = `MCD_MODE_XI;
               end
               2'h2: lbc_next = 1'b1;
               default: fetch_next = 1'b1;
            endcase
         end
         `MCD_CMD_RDA, `MCD_CMD_RDB:
         begin
            if (CMD_CODE[0] && CMD_SUB == 2'h2)
            begin
               ird2_next = 1'b1;
            end
            else if (CMD_CODE[0] && CMD_SUB == 2'h3)
            begin
               ard_next = 1'b1;
               amode_next = `MCD_MODE_NEXT;
            end
            else
            begin
               ard_next = 1'b1;
               amode_next = mode6;
            end
         end
         `MCD_CMD_WRA, `MCD_CMD_WRB:
         begin
            awr_next = 1'b1;
            amode_next = mode6;
            if (CMD_CODE[0] && CMD_SUB[1])
            begin
               amode_next = CMD_SUB[0] ? `MCD_MODE_NEXT : `MCD_MODE_HOLD;
            end
         end
         `MCD_CMD_RPT:
         begin
            brd_next = 1'b1;
            pt_next = CMD_SUB;
         end
         `MCD_CMD_WPT:
         begin
            bwr_next = 1'b1;
            pt_next = CMD_SUB;
         end
         `MCD_CMD_CSB:
         begin
            case (CMD_SUB)
               2'h0: csa_next = WRITABLE_CONTROL_STORE;
               2'h1: csx_next = WRITABLE_CONTROL_STORE;
               2'h2: llb_next = 1'b1;
               default: lalb_next = 1'b1;
            endcase
         end
         default:
         begin
            cond_microjump_next = 1'b0;
         end
      endcase
   end

   // Data bus source multiplexer with its enable path.
   always @*
   begin
      bus_next = 16'h0000;
      en_next = `MCD_EN_ALU;
      case (BUS_SOURCE_SELECT)
         `MCD_SRC_ALU: bus_next = ALU_RESULT;
         `MCD_SRC_BMG: bus_next = bm_word;
         `MCD_SRC_GPR: bus_next = GENERAL_REGISTER;
         `MCD_SRC_DRD: bus_next = DATA_READ_REGISTER;
         `MCD_SRC_ARG: bus_next = MICRO_ARGUMENT;
         `MCD_SRC_REG: bus_next = REGFILE_DATA;
         `MCD_SRC_STS: bus_next = STATUS_REGISTER;
         `MCD_SRC_B_OPERAND_ARGUMENT: bus_next = {12'h000, B_OPERAND};
         `MCD_SRC_SWAP: bus_next = SWAP_REGISTER;
         `MCD_SRC_PEA: bus_next = PARITY_ERROR_ADDR;
         `MCD_SRC_PES:
         begin
            bus_next = PARITY_ERROR_STATUS;
            en_next = `MCD_EN_MEM;
         end
         `MCD_SRC_A_OPERAND_ARGUMENT: bus_next = {9'h000, A_OPERAND, 3'h0};
         `MCD_SRC_IOR: bus_next = IO_CONTROL_REGISTER;
         `MCD_SRC_DSIF: bus_next = DISABLE_IF_DATA;
         `MCD_SRC_GSEX: bus_next = {{8{GENERAL_REGISTER[7]}}, GENERAL_REGISTER[7:0]};
         `MCD_SRC_PGS: bus_next = PAGING_STATUS;
         `MCD_SRC_PCR:
         begin
            bus_next = PAGING_CONTROL;
            en_next = `MCD_EN_MEM;
         end
         `MCD_SRC_ALD: bus_next = AL_DESCRIPTOR;
         `MCD_SRC_PANEL: bus_next = PANEL_VECTOR;
         `MCD_SRC_INTERRUPT_VECTOR_SOURCE: bus_next = INTERRUPT_VECTOR_SOURCE;
         `MCD_SRC_PTC:
         begin
            bus_next = PAGE_TABLE_CONTENT;
            en_next = `MCD_EN_MEM;
         end
         `MCD_SRC_LACA: bus_next = {LOCALITY_BITS, CONTROL_ADDR};
         `MCD_SRC_INSTALLATION_NUMBER_READ: bus_next = INSTALLATION_NUMBER;
         `MCD_SRC_FAST_INTERNAL_BUS:
         begin
            bus_next = FAST_INTERNAL_BUS;
            en_next = `MCD_EN_XFER;
         end
         default:
         begin
            bus_next = 16'h0000;
            en_next = 2'h0;
         end
      endcase
   end

   // Register every output once per microcycle.
   always @(posedge MCLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         COND_MICROJUMP <= 1'b0;
         COND_NEXT_MACRO <= 1'b0;
         MACRO_JUMP <= 1'b0;
         FETCH_NEXT <= 1'b0;
         LOGICAL_BANK_CONTINUE <= 1'b0;
         JUMP_MODE <= 3'h0;
         ADDR_MODE_READ <= 1'b0;
         ADDR_MODE_WRITE <= 1'b0;
         INDIRECT_FIRST_HALF_READ <= 1'b0;
         ADDR_MODE <= 3'h0;
         BUS_ADDR_READ <= 1'b0;
         BUS_ADDR_WRITE <= 1'b0;
         PAGE_TABLE_SEL <= 2'h0;
         SET_CONTROL_STORE_ADDR <= 1'b0;
         CONTROL_STORE_ACCESS <= 1'b0;
         LOAD_LOGICAL_BANK <= 1'b0;
         LOAD_ALT_LOGICAL_BANK <= 1'b0;
         INTERNAL_DATA_BUS <= 16'h0000;
         MEMORY_UNIT_OUT_ENABLE <= 1'b0;
         ALU_FAST_BUS_ENABLE <= 1'b0;
         BUS_TO_FAST_TRANSFER <= 1'b0;
      end
      else
      begin
         COND_MICROJUMP <= cond_microjump_next;
         COND_NEXT_MACRO <= cond_next_macro_next;
         MACRO_JUMP <= mjmp_next;
         FETCH_NEXT <= fetch_next;
         LOGICAL_BANK_CONTINUE <= lbc_next;
         JUMP_MODE <= jmode_next;
         ADDR_MODE_READ <= ard_next;
         ADDR_MODE_WRITE <= awr_next;
         INDIRECT_FIRST_HALF_READ <= ird2_next;
         ADDR_MODE <= amode_next;
         BUS_ADDR_READ <= brd_next;
         BUS_ADDR_WRITE <= bwr_next;
         PAGE_TABLE_SEL <= pt_next;
         SET_CONTROL_STORE_ADDR <= csa_next;
         CONTROL_STORE_ACCESS <= csx_next;
         LOAD_LOGICAL_BANK <= llb_next;
         LOAD_ALT_LOGICAL_BANK <= lalb_next;
         INTERNAL_DATA_BUS <= bus_next;
         // At most one enable path is raised; an absent source raises none.
         MEMORY_UNIT_OUT_ENABLE <= (en_next == `MCD_EN_MEM);
         ALU_FAST_BUS_ENABLE <= (en_next == `MCD_EN_ALU);
         BUS_TO_FAST_TRANSFER <= (en_next == `MCD_EN_XFER);
      end
   end

endmodule // mcd_decode
`default_nettype wire

// [tb/mcd_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module mcd_checker (
   // Clock, reset and strap.
   input wire logic MCLK, RESET_N, WRITABLE_CONTROL_STORE,
   // Condition flags.
   input wire logic SIGN_FLAG, ZERO_FLAG, SIGNED_GREATER_FLAG, CARRY_FLAG,
   // Fields and operands.
   input wire logic [4:0] CMD_CODE, BUS_SOURCE_SELECT,
   input wire logic [1:0] CMD_SUB,
   input wire logic [3:0] B_OPERAND,
   input wire logic [5:0] LOCALITY_BITS,
   input wire logic [9:0] CONTROL_ADDR,
   // Decoded controls.
   input wire logic COND_MICROJUMP, COND_NEXT_MACRO, MACRO_JUMP,
   input wire logic ADDR_MODE_READ, ADDR_MODE_WRITE, BUS_ADDR_READ, BUS_ADDR_WRITE,
   input wire logic SET_CONTROL_STORE_ADDR, CONTROL_STORE_ACCESS,
   input wire logic [2:0] JUMP_MODE, ADDR_MODE,
   input wire logic [1:0] PAGE_TABLE_SEL,
   // Data bus and enables.
   input wire logic [15:0] INTERNAL_DATA_BUS,
   input wire logic MEMORY_UNIT_OUT_ENABLE, ALU_FAST_BUS_ENABLE, BUS_TO_FAST_TRANSFER
);
   logic cj_exp;
   logic cn_exp;
   logic [2:0] en;

   // Condition expected from the flags; odd sub codes test the false sense.
   assign cj_exp = CMD_SUB[1] ? ZERO_FLAG ^ CMD_SUB[0] : SIGN_FLAG ^ CMD_SUB[0];
   assign cn_exp = (CMD_CODE == 5'h15) ? cj_exp :
      (CMD_SUB[1] ? CARRY_FLAG ^ CMD_SUB[0] : SIGNED_GREATER_FLAG ^ CMD_SUB[0]);
   assign en = {MEMORY_UNIT_OUT_ENABLE, ALU_FAST_BUS_ENABLE, BUS_TO_FAST_TRANSFER};

   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESET_N);

   a_cond_jump:
      assert property (CMD_CODE == 5'h13 |=> COND_MICROJUMP == $past(cj_exp))
      else $error("conditional microjump wrong");
   a_cond_next:
      assert property (CMD_CODE inside {5'h14, 5'h15} |=> COND_NEXT_MACRO == $past(cn_exp))
      else $error("conditional next wrong");
   a_jump_mode:
      assert property (CMD_CODE == 5'h16 |=> MACRO_JUMP && JUMP_MODE == {1'b0, $past(CMD_SUB)})
      else $error("macro jump mode wrong");
   a_read_mode:
      assert property (CMD_CODE == 5'h18 |=> ADDR_MODE_READ && ADDR_MODE == {1'b0, $past(CMD_SUB)})
      else $error("read mode wrong");
   a_read_second:
      assert property (CMD_CODE == 5'h19 && !CMD_SUB[1]
         |=> ADDR_MODE_READ && ADDR_MODE == {2'h2, $past(CMD_SUB[0])})
      else $error("second read mode wrong");
   a_write_hold:
      assert property (CMD_CODE == 5'h1b && CMD_SUB == 2'h2 |-> ##1 ADDR_MODE_WRITE && ADDR_MODE == 3'h7)
      else $error("hold write wrong");
   a_page_sel:
      assert property (CMD_CODE == 5'h1c |=> BUS_ADDR_READ && PAGE_TABLE_SEL == $past(CMD_SUB))
      else $error("page table select wrong");
   a_cs_gate:
      assert property (CMD_CODE == 5'h1e && !CMD_SUB[1] && !WRITABLE_CONTROL_STORE
         |=> !SET_CONTROL_STORE_ADDR && !CONTROL_STORE_ACCESS)
      else $error("control store acted without option");
   a_mask_onehot:
      assert property (BUS_SOURCE_SELECT == 5'h01 |=> $onehot(INTERNAL_DATA_BUS))
      else $error("bit mask not one-hot");
   a_b_operand_argument_low:
      assert property (BUS_SOURCE_SELECT == 5'h08 |=> INTERNAL_DATA_BUS == {12'h0, $past(B_OPERAND)})
      else $error("B operand word wrong");
   a_locality_join:
      assert property (BUS_SOURCE_SELECT == 5'h1c
         |=> INTERNAL_DATA_BUS == {$past(LOCALITY_BITS), $past(CONTROL_ADDR)})
      else $error("locality word wrong");
   a_status_path:
      assert property (BUS_SOURCE_SELECT == 5'h0b |=> en == 3'h4)
      else $error("parity status path wrong");
   a_absent_zero:
      assert property (BUS_SOURCE_SELECT inside {5'h07, 5'h0d, 5'h10, 5'h11, 5'h14, 5'h18,
         5'h1a, 5'h1e} |=> INTERNAL_DATA_BUS == 16'h0 && en == 3'h0)
      else $error("absent source not quiet");

   // Main scenarios reached.
   c_jump: cover property (COND_MICROJUMP);
   c_phys: cover property (BUS_ADDR_WRITE && PAGE_TABLE_SEL == 2'h3);
   c_xfer: cover property (BUS_TO_FAST_TRANSFER);
endmodule // mcd_checker

bind mcd_decode mcd_checker chk (.*);
`default_nettype wire

// [tb/mcd_datapath_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mcd_datapath_model (
   // Pattern selector.
   input wire logic [3:0] salt,
   // Source words, each distinct so a wrong selection shows.
   output logic [15:0] ALU_RESULT, GENERAL_REGISTER, DATA_READ_REGISTER, MICRO_ARGUMENT,
   output logic [15:0] REGFILE_DATA, STATUS_REGISTER, SWAP_REGISTER, PARITY_ERROR_ADDR,
   output logic [15:0] PARITY_ERROR_STATUS, IO_CONTROL_REGISTER, DISABLE_IF_DATA,
   output logic [15:0] PAGING_STATUS, PAGING_CONTROL, AL_DESCRIPTOR, PANEL_VECTOR,
   output logic [15:0] INTERRUPT_VECTOR_SOURCE, PAGE_TABLE_CONTENT, INSTALLATION_NUMBER,
   output logic [15:0] FAST_INTERNAL_BUS,
   // Operand fields.
   output logic [3:0] MASK_POS, B_OPERAND, A_OPERAND,
   output logic [5:0] LOCALITY_BITS,
   output logic [9:0] CONTROL_ADDR
);
   function automatic logic [15:0] pat(input logic [4:0] k, input logic [3:0] s);
      return {k, s, ~s, k[2:0]};
   endfunction

   // Every word carries its own index and the salt.
   assign ALU_RESULT = pat(5'h01, salt);
   assign GENERAL_REGISTER = pat(5'h02, salt);
   assign DATA_READ_REGISTER = pat(5'h03, salt);
   assign MICRO_ARGUMENT = pat(5'h04, salt);
   assign REGFILE_DATA = pat(5'h05, salt);
   assign STATUS_REGISTER = pat(5'h06, salt);
   assign SWAP_REGISTER = pat(5'h07, salt);
   assign PARITY_ERROR_ADDR = pat(5'h08, salt);
   assign PARITY_ERROR_STATUS = pat(5'h09, salt);
   assign IO_CONTROL_REGISTER = pat(5'h0a, salt);
   assign DISABLE_IF_DATA = pat(5'h0b, salt);
   assign PAGING_STATUS = pat(5'h0c, salt);
   assign PAGING_CONTROL = pat(5'h0d, salt);
   assign AL_DESCRIPTOR = pat(5'h0e, salt);
   assign PANEL_VECTOR = pat(5'h0f, salt);
   assign INTERRUPT_VECTOR_SOURCE = pat(5'h10, salt);
   assign PAGE_TABLE_CONTENT = pat(5'h11, salt);
   assign INSTALLATION_NUMBER = pat(5'h12, salt);
   assign FAST_INTERNAL_BUS = pat(5'h13, salt);
   // Operand fields follow the salt so every mask position is reached.
   assign MASK_POS = salt;
   assign B_OPERAND = ~salt;
   assign A_OPERAND = salt + 4'h5;
   assign LOCALITY_BITS = {salt, 2'h2};
   assign CONTROL_ADDR = {~salt, 6'h2b};
endmodule // mcd_datapath_model
`default_nettype wire

// [tb/tb_microcode_command_idb_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_microcode_command_idb_decode;
   logic MCLK, RESET_N, WRITABLE_CONTROL_STORE, SIGN_FLAG, ZERO_FLAG, SIGNED_GREATER_FLAG;
   logic CARRY_FLAG, COND_MICROJUMP, COND_NEXT_MACRO, MACRO_JUMP, FETCH_NEXT;
   logic LOGICAL_BANK_CONTINUE, ADDR_MODE_READ, ADDR_MODE_WRITE, INDIRECT_FIRST_HALF_READ;
   logic BUS_ADDR_READ, BUS_ADDR_WRITE, SET_CONTROL_STORE_ADDR, CONTROL_STORE_ACCESS;
   logic LOAD_LOGICAL_BANK, LOAD_ALT_LOGICAL_BANK, MEMORY_UNIT_OUT_ENABLE;
   logic ALU_FAST_BUS_ENABLE, BUS_TO_FAST_TRANSFER;
   logic [4:0] CMD_CODE, BUS_SOURCE_SELECT;
   logic [1:0] CMD_SUB, PAGE_TABLE_SEL;
   logic [2:0] JUMP_MODE, ADDR_MODE;
   logic [3:0] salt, MASK_POS, B_OPERAND, A_OPERAND;
   logic [5:0] LOCALITY_BITS;
   logic [9:0] CONTROL_ADDR;
   logic [15:0] ALU_RESULT, GENERAL_REGISTER, DATA_READ_REGISTER, MICRO_ARGUMENT;
   logic [15:0] REGFILE_DATA, STATUS_REGISTER, SWAP_REGISTER, PARITY_ERROR_ADDR;
   logic [15:0] PARITY_ERROR_STATUS, IO_CONTROL_REGISTER, DISABLE_IF_DATA, PAGING_STATUS;
   logic [15:0] PAGING_CONTROL, AL_DESCRIPTOR, PANEL_VECTOR, INTERRUPT_VECTOR_SOURCE;
   logic [15:0] PAGE_TABLE_CONTENT, INSTALLATION_NUMBER, FAST_INTERNAL_BUS, INTERNAL_DATA_BUS;
   logic [21:0] got_ctl, got_bus;
   int checks = 0;
   int n_mismatch = 0;

   mcd_decode uut (.*);
   mcd_datapath_model mdl (.*);

   // Mode fields only count while their strobe is up.
   assign got_ctl = {COND_MICROJUMP, COND_NEXT_MACRO, MACRO_JUMP, FETCH_NEXT,
      LOGICAL_BANK_CONTINUE, MACRO_JUMP ? JUMP_MODE : 3'h0, ADDR_MODE_READ, ADDR_MODE_WRITE,
      INDIRECT_FIRST_HALF_READ, (ADDR_MODE_READ | ADDR_MODE_WRITE) ? ADDR_MODE : 3'h0,
      BUS_ADDR_READ, BUS_ADDR_WRITE, (BUS_ADDR_READ | BUS_ADDR_WRITE) ? PAGE_TABLE_SEL : 2'h0,
      SET_CONTROL_STORE_ADDR, CONTROL_STORE_ACCESS, LOAD_LOGICAL_BANK, LOAD_ALT_LOGICAL_BANK};
   assign got_bus = {3'h0, MEMORY_UNIT_OUT_ENABLE, ALU_FAST_BUS_ENABLE, BUS_TO_FAST_TRANSFER,
      INTERNAL_DATA_BUS};

   // Clock at 250 MHz.
   always #2 MCLK = ~MCLK;

   // Expected controls for a command; flags are {carry, greater, zero, sign}.
   function automatic logic [21:0] ectl(input logic [4:0] c, input logic [1:0] s,
      input logic [3:0] f, input logic w);
      logic cj, cn, mj, fn, lb, rd, wr, ih, br, bw, sa, ca, l1, l2;
      logic [2:0] jm, am;
      logic [1:0] pt;
      {cj, cn, mj, fn, lb, rd, wr, ih, br, bw, sa, ca, l1, l2, jm, am, pt} = 22'h0;
      case (c)
         5'h13: cj = s[1] ? f[1] ^ s[0] : f[0] ^ s[0];
         5'h14: cn = s[1] ? f[3] ^ s[0] : f[2] ^ s[0];
         5'h15: cn = s[1] ? f[1] ^ s[0] : f[0] ^ s[0];
         5'h16: {mj, jm} = {2'h2, s};
         5'h17: {mj, jm, lb, fn} = s[1] ? {4'h0, !s[0], s[0]} : {3'h6, s[0], 2'h0};
         5'h18: {rd, am} = {2'h2, s};
         5'h19: {ih, rd, am} = (s == 2'h2) ? 5'h10 : {2'h1, (s == 2'h3) ? 3'h6 : {2'h2, s[0]}};
         5'h1a: {wr, am} = {2'h2, s};
         5'h1b: {wr, am} = {1'b1, s[1] ? {2'h3, !s[0]} : {2'h2, s[0]}};
         5'h1c: {br, pt} = {1'b1, s};
         5'h1d: {bw, pt} = {1'b1, s};
         5'h1e: {sa, ca, l1, l2} = {w && s == 2'h0, w && s == 2'h1, s == 2'h2, s == 2'h3};
         default: ;
      endcase
      return {cj, cn, mj, fn, lb, jm, rd, wr, ih, am, br, bw, pt, sa, ca, l1, l2};
   endfunction

   // Expected {memory, ALU, transfer} enables and bus word for a source code.
   function automatic logic [18:0] ebus(input logic [4:0] b);
      case (b)
         5'h00: return {3'h2, ALU_RESULT};
         5'h01: return {3'h2, 16'h1 << MASK_POS};
         5'h02: return {3'h2, GENERAL_REGISTER};
         5'h03: return {3'h2, DATA_READ_REGISTER};
         5'h04: return {3'h2, MICRO_ARGUMENT};
         5'h05: return {3'h2, REGFILE_DATA};
         5'h06: return {3'h2, STATUS_REGISTER};
         5'h08: return {3'h2, 12'h0, B_OPERAND};
         5'h09: return {3'h2, SWAP_REGISTER};
         5'h0a: return {3'h2, PARITY_ERROR_ADDR};
         5'h0b: return {3'h4, PARITY_ERROR_STATUS};
         5'h0c: return {3'h2, 9'h0, A_OPERAND, 3'h0};
         5'h0e: return {3'h2, IO_CONTROL_REGISTER};
         5'h0f: return {3'h2, DISABLE_IF_DATA};
         5'h12: return {3'h2, {8{GENERAL_REGISTER[7]}}, GENERAL_REGISTER[7:0]};
         5'h13: return {3'h2, PAGING_STATUS};
         5'h15: return {3'h4, PAGING_CONTROL};
         5'h16: return {3'h2, AL_DESCRIPTOR};
         5'h17: return {3'h2, PANEL_VECTOR};
         5'h19: return {3'h2, INTERRUPT_VECTOR_SOURCE};
         5'h1b: return {3'h4, PAGE_TABLE_CONTENT};
         5'h1c: return {3'h2, LOCALITY_BITS, CONTROL_ADDR};
         5'h1d: return {3'h2, INSTALLATION_NUMBER};
         5'h1f: return {3'h1, FAST_INTERNAL_BUS};
         default: return 19'h0;
      endcase
   endfunction

   task chk(input logic [21:0] g, input logic [21:0] e);
      checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("FAIL at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Present one microinstruction, then look after the edge that registers it.
   task op(input logic [4:0] c, input logic [1:0] s, input logic [3:0] f, input logic [4:0] b);
      @(posedge MCLK);
      CMD_CODE <= c;
      CMD_SUB <= s;
      {CARRY_FLAG, SIGNED_GREATER_FLAG, ZERO_FLAG, SIGN_FLAG} <= f;
      WRITABLE_CONTROL_STORE <= f[1] ^ f[2];
      BUS_SOURCE_SELECT <= b;
      salt <= f;
      @(posedge MCLK);
      #1;
      chk(got_ctl, ectl(c, s, f, f[1] ^ f[2]));
      chk(got_bus, {3'h0, ebus(b)});
   endtask

   // Reset with command code 0 and the ALU source, so no check straddles the release.
   task hold_reset;
      @(posedge MCLK);
      CMD_CODE <= 5'h0;
      BUS_SOURCE_SELECT <= 5'h0;
      RESET_N <= 1'b0;
      repeat (10) @(posedge MCLK);
      #1;
      chk(got_ctl | got_bus, 22'h0);
      @(posedge MCLK);
      RESET_N <= 1'b1;
   endtask

   task conclude;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Watchdog well beyond the expected run.
   initial
   begin
      #60000;
      n_mismatch++;
      conclude;
   end

   initial
   begin
      MCLK = 1'b0;
      CMD_SUB = 2'h0;
      salt = 4'h0;
      {CARRY_FLAG, SIGNED_GREATER_FLAG, ZERO_FLAG, SIGN_FLAG, WRITABLE_CONTROL_STORE} = 5'h0;
      hold_reset;
      // Every command and minor code under all flag patterns, sources sweeping alongside.
      for (int c = 18; c < 32; c++)
         for (int s = 0; s < 4; s++)
            for (int f = 0; f < 16; f++)
               op(5'(c), 2'(s), 4'(f), 5'(c * 4 + s + f));
      $display("command and source sweep done");
      hold_reset;
      op(5'h13, 2'h0, 4'h1, 5'h17);
      $display("reset recovery done");
      conclude;
   end
endmodule // tb_microcode_command_idb_decode
`default_nettype wire
